// ==== shared/lpw_defs.vh ====
// Constants for the low-power wake controller: offsets, fields, resets, timing
`ifndef LPW_DEFS_VH
`define LPW_DEFS_VH

// Register offsets (byte address on the 4-bit register port)
`define LPW_REG_PWR_CTRL 4'h0
`define LPW_REG_WAKE_EN  4'h1
`define LPW_REG_IRQ_STAT 4'h2
`define LPW_REG_IRQ_MASK 4'h3
`define LPW_REG_PORT2    4'h4
`define LPW_REG_PORT0    4'h5

// Power control fields
`define LPW_PWR_IDLE_BIT  0
`define LPW_PWR_PDOWN_BIT 1

// Wake enable fields
`define LPW_WEN_IRQ0_BIT 0
`define LPW_WEN_IRQ1_BIT 1
`define LPW_WEN_RX_BIT   2

// Event status fields
`define LPW_EV_IDLE_EXIT 0
`define LPW_EV_WAKE_IRQ0 1
`define LPW_EV_WAKE_IRQ1 2
`define LPW_EV_WAKE_RX   3

// Reset values
`define LPW_RST_WAKE_EN 3'h0
`define LPW_RST_MASK    4'h0
`define LPW_RST_PORT    8'hff

// Timing: oscillator restart hold time and clock rate
`define LPW_OSC_RESTART_NS 2000
`define LPW_CLK_MHZ        125
`define LPW_OSC_RESTART_CYC ((`LPW_OSC_RESTART_NS * `LPW_CLK_MHZ + 999) / 1000)

`endif

// ==== rtl/lpw_wake_ctrl.v ====
// Low-power mode and power-down wake controller of the embedded core
//
// Added by the designer: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "lpw_defs.vh"

// Operation
// RQ1 - Static core: clock may stop fully; all state kept while halted.
// RQ2 - Idle stops instruction execution; peripherals keep running.
// RQ3 - Idle request instruction completes last; nothing more runs until idle ends.
// RQ4 - Idle keeps processor state, RAM and special registers unchanged.
// RQ5 - Idle ends on enabled interrupt or hardware reset like power-on.
// RQ6 - Power-down stops the oscillator after the requesting instruction.
// RQ7 - Power-down exits on reset, external interrupt or receive line activity.
// RQ8 - Reset wake reinitialises registers not RAM; interrupt wake keeps both.
// RQ9 - Software enables wake interrupts before entering power-down.
// RQ10 - Interrupt 0 handler reads status registers to find and clear cause.
// RQ11 - Interrupt 1 wake needs its enable bit set first.
// RQ12 - Receive wake needs interrupt 1 and receive wake enables set.
// RQ13 - Delay counter holds interrupt lines low while oscillator restarts.
// RQ14 - After servicing wake interrupt, execution resumes after power-down instruction.
// RQ15 - Strobe pins high in idle, low in power-down; ports per mode table.
// RQ16 - Port two gives high address for fetch and 16-bit data accesses.
// RQ17 - Port zero floats where latch holds ones; muxed address/data bus.
// RQ18 - Internal clock is crystal divided by two, duty cycle irrelevant.
// RQ19 - Wake events are synchronised before releasing the processor.
module lpw_wake_ctrl #(
   parameter AW = 4,
   parameter DW = 8
) (
   input  wire          clk_i,
   input  wire          rst_b_i,
   input  wire [AW-1:0] reg_addr_i,
   input  wire [DW-1:0] reg_wdata_i,
   input  wire          reg_wr_i,
   input  wire          reg_rd_i,
   output reg  [DW-1:0] reg_rdata_o,
   input  wire          instr_done_i,
   input  wire          core_irq_i,
   input  wire          ext_prog_i,
   input  wire          cpu_ale_i,
   input  wire          cpu_psen_b_i,
   input  wire          cpu_ext_cycle_i,
   input  wire          cpu_addr16_i,
   input  wire [7:0]    cpu_addr_hi_i,
   input  wire [7:0]    cpu_ad_out_i,
   input  wire          ext_irq0_pin_i,
   input  wire          ext_irq1_pin_i,
   input  wire          rxd_pin_i,
   output reg           core_clk_en_o,
   output wire          cpu_run_o,
   output wire          periph_run_o,
   output wire          osc_run_o,
   output wire          ext_irq0_int_b_o,
   output wire          ext_irq1_int_b_o,
   output reg           ale_o,
   output reg           program_store_strobe_b_o,
   output reg  [7:0]    port0_o,
   output reg  [7:0]    port0_oe_o,
   output reg  [7:0]    port_two_latch_o,
   output wire [1:0]    mode_o,
   output wire          irq_o
);

   // -------------------------------------------------------------
   // Mode states
   // -------------------------------------------------------------
   localparam [1:0] ST_RUN   = 2'd0;
   localparam [1:0] ST_IDLE  = 2'd1;
   localparam [1:0] ST_PDOWN = 2'd2;
   localparam [1:0] ST_WAKE  = 2'd3;
   localparam integer RESTART_INT = `LPW_OSC_RESTART_CYC;
   localparam [11:0] RESTART_CYC = RESTART_INT[11:0];   // Hold length fits in 12 bits

   reg [1:0]  state;
   reg [1:0]  next_state;
   reg [11:0] delay_cnt;
   reg        idle_pend;
   reg        pdown_pend;
   reg [2:0]  wake_en;
   reg [3:0]  irq_stat;
   reg [3:0]  irq_mask;
   reg [7:0]  port2_latch;
   reg [7:0]  port0_latch;
   reg [7:0]  addr_hi_hold;
   reg        hold0;
   reg        hold1;
   reg        div2;
   reg [2:0]  sync_a;
   reg [2:0]  sync_b;
   reg [2:0]  sync_d;
   reg [3:0]  ev_set;

   // -------------------------------------------------------------
   // Pin synchronisers and falling edge detect
   // -------------------------------------------------------------
   // RQ19 two-stage sync
   always @(posedge clk_i) begin
      if (!rst_b_i) begin
         sync_a <= 3'h7;
         sync_b <= 3'h7;
         sync_d <= 3'h7;
      end else begin
         sync_a <= {rxd_pin_i, ext_irq1_pin_i, ext_irq0_pin_i};
         sync_b <= sync_a;
         sync_d <= sync_b;
      end
   end

   wire [2:0] fall = sync_d & ~sync_b;   // Bit0 irq0, bit1 irq1, bit2 rx

   // RQ7 wake sources
   // RQ12 rx needs both enables
   wire wake0 = fall[0] & wake_en[`LPW_WEN_IRQ0_BIT];
   wire wake1 = fall[1] & wake_en[`LPW_WEN_IRQ1_BIT];
   wire wakerx = fall[2] & wake_en[`LPW_WEN_IRQ1_BIT] & wake_en[`LPW_WEN_RX_BIT];
   wire wake_any = wake0 | wake1 | wakerx;

   // -------------------------------------------------------------
   // Mode sequencer
   // -------------------------------------------------------------
   // RQ3 request taken only when its instruction has completed
   always @* begin
      next_state = state;
      ev_set = 4'h0;
      case (state)
         ST_RUN: begin
            if (instr_done_i && pdown_pend)
               next_state = ST_PDOWN;
            else if (instr_done_i && idle_pend)
               next_state = ST_IDLE;
         end
         // RQ5 enabled interrupt ends idle
         ST_IDLE: begin
            if (core_irq_i) begin
               next_state = ST_RUN;
               ev_set[`LPW_EV_IDLE_EXIT] = 1'b1;
            end
         end
         // RQ7 wake from power-down
         ST_PDOWN: begin
            if (wake_any) begin
               next_state = ST_WAKE;
               ev_set[`LPW_EV_WAKE_IRQ0] = wake0;
               ev_set[`LPW_EV_WAKE_IRQ1] = wake1;
               ev_set[`LPW_EV_WAKE_RX] = wakerx;
            end
         end
         ST_WAKE: begin
            if (delay_cnt == 12'h000)
               next_state = ST_RUN;
         end
         default: next_state = ST_RUN;
      endcase
   end

   // RQ5 hardware reset restarts as power-on
   // RQ8 reset reinitialises registers only; RAM lives outside this block
   always @(posedge clk_i) begin
      if (!rst_b_i)
         state <= ST_RUN;
      else
         state <= next_state;
   end

   // RQ13 delay counter keeps lines low during restart
   always @(posedge clk_i) begin
      if (!rst_b_i) begin
         delay_cnt <= 12'h000;
         hold0 <= 1'b0;
         hold1 <= 1'b0;
      end else if (state == ST_PDOWN && wake_any) begin
         delay_cnt <= RESTART_CYC - 12'h001;
         hold0 <= wake0;
         hold1 <= wake1 | wakerx;  // Receive wake is routed to line 1
      end else if (state == ST_WAKE && delay_cnt != 12'h000) begin
         delay_cnt <= delay_cnt - 12'h001;
      end else begin
         hold0 <= 1'b0;
         hold1 <= 1'b0;
      end
   end

   // RQ13 internal interrupt lines forced low while held
   assign ext_irq0_int_b_o = sync_b[0] & ~hold0;
   assign ext_irq1_int_b_o = sync_b[1] & ~hold1;

   // RQ2 core halts, peripherals run in idle
   // RQ4 dropping the core run enable keeps core state intact
   // RQ14 core resumes where it stopped; the held line vectors it first
   assign cpu_run_o = (state == ST_RUN);
   assign periph_run_o = (state == ST_RUN) | (state == ST_IDLE);
   // RQ6 oscillator stopped in power-down
   // RQ1 static logic tolerates the stop
   assign osc_run_o = (state != ST_PDOWN);
   assign mode_o = state;

   // -------------------------------------------------------------
   // Divide-by-two internal clock phase
   // -------------------------------------------------------------
   // RQ18 toggle stage removes input duty cycle dependence
   always @(posedge clk_i) begin
      if (!rst_b_i) begin
         div2 <= 1'b0;
         core_clk_en_o <= 1'b0;
      end else begin
         div2 <= ~div2 & osc_run_o;
         core_clk_en_o <= div2 & osc_run_o;
      end
   end

   // -------------------------------------------------------------
   // Register port
   // -------------------------------------------------------------
   wire wr_pwr  = reg_wr_i && reg_addr_i == `LPW_REG_PWR_CTRL;
   wire wr_stat = reg_wr_i && reg_addr_i == `LPW_REG_IRQ_STAT;

   // Software registers; a write sets pending requests, an instruction completing in run clears them
   always @(posedge clk_i) begin
      if (!rst_b_i) begin
         idle_pend <= 1'b0;
         pdown_pend <= 1'b0;
         wake_en <= `LPW_RST_WAKE_EN;
         irq_mask <= `LPW_RST_MASK;
         port2_latch <= `LPW_RST_PORT;
         port0_latch <= `LPW_RST_PORT;
      end else begin
         if (wr_pwr) begin
            idle_pend <= reg_wdata_i[`LPW_PWR_IDLE_BIT];
            pdown_pend <= reg_wdata_i[`LPW_PWR_PDOWN_BIT];
         end else if (state == ST_RUN && instr_done_i) begin
            idle_pend <= 1'b0;
            pdown_pend <= 1'b0;
         end
         if (reg_wr_i && reg_addr_i == `LPW_REG_WAKE_EN)
            wake_en <= reg_wdata_i[2:0];
         if (reg_wr_i && reg_addr_i == `LPW_REG_IRQ_MASK)
            irq_mask <= reg_wdata_i[3:0];
         if (reg_wr_i && reg_addr_i == `LPW_REG_PORT2)
            port2_latch <= reg_wdata_i;
         if (reg_wr_i && reg_addr_i == `LPW_REG_PORT0)
            port0_latch <= reg_wdata_i;
      end
   end

   // Sticky events, write one to clear; a new event beats the clear
   always @(posedge clk_i) begin
      if (!rst_b_i)
         irq_stat <= 4'h0;
      else if (wr_stat)
         irq_stat <= (irq_stat & ~reg_wdata_i[3:0]) | ev_set;
      else
         irq_stat <= irq_stat | ev_set;
   end

   assign irq_o = |(irq_stat & irq_mask);

   // Read data one cycle after the strobe; unmapped reads return zero
   always @(posedge clk_i) begin
      if (!rst_b_i) begin
         reg_rdata_o <= 8'h00;
      end else if (reg_rd_i) begin
         case (reg_addr_i)
            `LPW_REG_PWR_CTRL: reg_rdata_o <= {4'h0, state, pdown_pend, idle_pend};
            `LPW_REG_WAKE_EN:  reg_rdata_o <= {5'h00, wake_en};
            `LPW_REG_IRQ_STAT: reg_rdata_o <= {4'h0, irq_stat};
            `LPW_REG_IRQ_MASK: reg_rdata_o <= {4'h0, irq_mask};
            `LPW_REG_PORT2:    reg_rdata_o <= port2_latch;
            `LPW_REG_PORT0:    reg_rdata_o <= port0_latch;
            default:           reg_rdata_o <= 8'h00;
         endcase
      end else begin
         reg_rdata_o <= 8'h00;
      end
   end

   // -------------------------------------------------------------
   // Bus pins per mode
   // -------------------------------------------------------------
   // Last high address kept so idle can keep showing it
   always @(posedge clk_i) begin
      if (!rst_b_i)
         addr_hi_hold <= 8'h00;
      else if (state == ST_RUN && cpu_ext_cycle_i && cpu_addr16_i)
         addr_hi_hold <= cpu_addr_hi_i;
   end

   // RQ15 strobes and ports in idle and power-down
   // RQ16 port two source selection
   // RQ17 open-drain port zero, muxed bus in external cycles
   always @(posedge clk_i) begin
      if (!rst_b_i) begin
         ale_o <= 1'b0;
         program_store_strobe_b_o <= 1'b1;
         port0_o <= 8'h00;
         port0_oe_o <= 8'h00;
         port_two_latch_o <= `LPW_RST_PORT;
      end else if (state == ST_RUN) begin
         ale_o <= cpu_ale_i;
         program_store_strobe_b_o <= cpu_psen_b_i;
         if (cpu_ext_cycle_i) begin
            port0_o <= cpu_ad_out_i;
            port0_oe_o <= 8'hff;
         end else begin
            port0_o <= 8'h00;
            port0_oe_o <= ~port0_latch;
         end
         if (cpu_ext_cycle_i && cpu_addr16_i)
            port_two_latch_o <= cpu_addr_hi_i;
         else
            port_two_latch_o <= port2_latch;
      end else begin
         // Idle drives strobes high, power-down and wake low
         ale_o <= (state == ST_IDLE);
         program_store_strobe_b_o <= (state == ST_IDLE);
         port0_o <= 8'h00;
         port0_oe_o <= ext_prog_i ? 8'h00 : ~port0_latch;
         if (state == ST_IDLE && ext_prog_i)
            port_two_latch_o <= addr_hi_hold;
         else
            port_two_latch_o <= port2_latch;
      end
   end

endmodule
`default_nettype wire

// ==== verif/lpw_wake_checker.sv ====
// Checker of mode, pin and wake timing of the wake controller
`timescale 1ns/1ps
`default_nettype none
module lpw_wake_checker (
   input wire logic       clk_i,
   input wire logic       rst_b_i,
   input wire logic       core_irq_i,
   input wire logic       instr_done_i,
   input wire logic       ext_prog_i,
   input wire logic       cpu_ext_cycle_i,
   input wire logic       cpu_addr16_i,
   input wire logic [7:0] cpu_addr_hi_i,
   input wire logic [7:0] cpu_ad_out_i,
   input wire logic       core_clk_en_o,
   input wire logic       cpu_run_o,
   input wire logic       periph_run_o,
   input wire logic       osc_run_o,
   input wire logic       ext_irq0_int_b_o,
   input wire logic       ext_irq1_int_b_o,
   input wire logic       ale_o,
   input wire logic       program_store_strobe_b_o,
   input wire logic [7:0] port0_o,
   input wire logic [7:0] port0_oe_o,
   input wire logic [7:0] port_two_latch_o,
   input wire logic [1:0] mode_o
);
   logic [8:0] wcnt;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   // Cycles spent holding the lines while the oscillator restarts
   always_ff @(posedge clk_i) begin
      if (!rst_b_i || mode_o != 2'h3) begin
         wcnt <= 9'h000;
      end else begin
         wcnt <= wcnt + 9'h001;
      end
   end
   run_gate_a: assert property (mode_o != 2'h0 |-> !cpu_run_o)
      else $error("core runs outside run mode");
   run_hold_a: assert property (mode_o == 2'h0 && !instr_done_i |=> mode_o == 2'h0)
      else $error("run left without a completed instruction");
   idle_periph_a: assert property (mode_o == 2'h1 |-> periph_run_o)
      else $error("peripherals stopped in idle");
   idle_exit_a: assert property (mode_o == 2'h1 && core_irq_i |=> mode_o == 2'h0)
      else $error("idle not left on interrupt");
   pdown_osc_a: assert property (mode_o == 2'h2 |-> !osc_run_o && !periph_run_o)
      else $error("oscillator runs in power-down");
   pdown_exit_a: assert property (mode_o == 2'h2 ##1 mode_o != 2'h2 |-> mode_o == 2'h3)
      else $error("power-down left without restart hold");
   wake_hold_a: assert property (
      mode_o == 2'h3 |-> !(ext_irq0_int_b_o && ext_irq1_int_b_o))
      else $error("no interrupt line held low in restart");
   wake_len_a: assert property ($fell(mode_o == 2'h3) |-> wcnt == 9'h0fa && mode_o == 2'h0)
      else $error("restart hold length wrong");
   idle_pins_a: assert property (mode_o == 2'h1 |=> ale_o && program_store_strobe_b_o)
      else $error("strobes not high in idle");
   sleep_pins_a: assert property (mode_o[1] |=> !ale_o && !program_store_strobe_b_o)
      else $error("strobes not low in power-down");
   bus_float_a: assert property (mode_o != 2'h0 && ext_prog_i |=> port0_oe_o == 8'h00)
      else $error("port 0 driven while asleep");
   // Reset sampled low at the release edge still resets the pins, so skip that edge
   addr_hi_a: assert property (
      rst_b_i && mode_o == 2'h0 && cpu_ext_cycle_i && cpu_addr16_i
      |=> port_two_latch_o == $past(cpu_addr_hi_i))
      else $error("port 2 lacks high address");
   port0_bus_a: assert property (
      rst_b_i && mode_o == 2'h0 && cpu_ext_cycle_i
      |=> port0_o == $past(cpu_ad_out_i) && port0_oe_o == 8'hff)
      else $error("port 0 not carrying the bus");
   clk_div_a: assert property (core_clk_en_o |=> !core_clk_en_o)
      else $error("clock enable not halved");
   clk_stop_a: assert property (!osc_run_o ##1 !osc_run_o |-> !core_clk_en_o)
      else $error("clock enable while oscillator stopped");
endmodule
`default_nettype wire

// ==== verif/lpw_wake_src.sv ====
// Model of the external wake sources: two interrupt pins and the receive line
`timescale 1ns/1ps
`default_nettype none
module lpw_wake_src (
   input  wire logic       clk_i,
   input  wire logic [2:0] fire_i,
   output var  logic [2:0] pin_b_o
);
   logic [2:0] d1 = 3'h0;
   logic [2:0] d2 = 3'h0;
   initial pin_b_o = 3'h7;
   // short falling edge
   // Lines have pull-ups, so a released line goes back high
   always @(posedge clk_i) begin
      d1 <= fire_i;
      d2 <= d1;
      pin_b_o <= ~(fire_i | d1 | d2);
   end
endmodule
`default_nettype wire

// ==== verif/lpw_wake_ctrl_tb.sv ====
// Self-checking bench of the low-power wake controller
`timescale 1ns/1ps
`default_nettype none
`include "lpw_defs.vh"
module lpw_wake_ctrl_tb;
   logic        clk_i = 1'b0;
   logic        rst_b_i = 1'b0;
   logic [3:0]  addr = 4'h0;
   logic [7:0]  wdata = 8'h00;
   logic [7:0]  hi = 8'h00;
   logic [7:0]  ad = 8'h00;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic        done = 1'b0;
   logic        irq = 1'b0;
   logic [4:0]  misc = 5'h00;
   logic [2:0]  fire = 3'h0;
   logic [31:0] seed = 32'h00000062;
   wire  logic [2:0] pin_b;
   wire  logic [7:0] rdata;
   wire  logic [1:0] mode;
   wire  logic       cpu_run;
   wire  logic       osc_run;
   wire  logic       irq_out;
   int err_count = 0;
   int n_tests = 0;
   int cyc = 0;
   // ------------------------------------------
   // Helpers
   // ------------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   // Receive wake needs both the line 1 and receive enables
   function automatic logic [7:0] wen(input int k);
      return (k == 2) ? 8'h06 : (8'h01 << k);
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_i);
      wr <= 1'b0;
      #1;
   endtask
   task automatic rd_reg(input logic [3:0] a, input logic [7:0] exp);
      @(posedge clk_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_i);
      rd <= 1'b0;
      #1 chk(rdata, exp);
   endtask
   task automatic pulse(input logic [2:0] f, input logic d, input logic q);
      @(posedge clk_i);
      fire <= f;
      done <= d;
      irq <= q;
      @(posedge clk_i);
      fire <= 3'h0;
      done <= 1'b0;
      irq <= 1'b0;
      #1;
   endtask
   task automatic wait_mode(input logic [1:0] m, input int lim);
      for (int i = 0; i < lim && mode !== m; i++) begin
         @(posedge clk_i);
         #1;
      end
      chk({6'h00, mode}, {6'h00, m});
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   initial forever #4 clk_i = ~clk_i;
   // Random core bus traffic; ext cycles never touch the mode logic
   always @(posedge clk_i) begin
      seed <= xs(seed);
      {misc, hi, ad} <= seed[20:0];
   end
   // Hang guard well above the roughly one thousand cycles needed
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count++;
         finish_test();
      end
   end
   lpw_wake_src i_src (.clk_i(clk_i), .fire_i(fire), .pin_b_o(pin_b));
   lpw_wake_ctrl i_dut (
      .clk_i(clk_i), .rst_b_i(rst_b_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
      .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .instr_done_i(done),
      .core_irq_i(irq), .ext_prog_i(misc[0]), .cpu_ale_i(misc[1]), .cpu_psen_b_i(misc[2]),
      .cpu_ext_cycle_i(misc[3]), .cpu_addr16_i(misc[4]), .cpu_addr_hi_i(hi),
      .cpu_ad_out_i(ad), .ext_irq0_pin_i(pin_b[0]), .ext_irq1_pin_i(pin_b[1]),
      .rxd_pin_i(pin_b[2]), .core_clk_en_o(), .cpu_run_o(cpu_run), .periph_run_o(),
      .osc_run_o(osc_run), .ext_irq0_int_b_o(), .ext_irq1_int_b_o(), .ale_o(),
      .program_store_strobe_b_o(), .port0_o(), .port0_oe_o(), .port_two_latch_o(),
      .mode_o(mode), .irq_o(irq_out));
   // Main sequence: registers, idle, each wake source, disabled source, reset wake
   initial begin
      logic [7:0] v;
      repeat (20) @(posedge clk_i);
      rst_b_i <= 1'b1;
      rd_reg(`LPW_REG_PORT2, 8'hff);
      rd_reg(`LPW_REG_WAKE_EN, 8'h00);
      rd_reg(`LPW_REG_IRQ_MASK, 8'h00);
      rd_reg(4'hf, 8'h00);
      for (int i = 0; i < 4; i++) begin
         v = seed[31:24];
         wr_reg(i[0] ? `LPW_REG_PORT0 : `LPW_REG_PORT2, v);
         rd_reg(i[0] ? `LPW_REG_PORT0 : `LPW_REG_PORT2, v);
      end
      wr_reg(`LPW_REG_PWR_CTRL, 8'h01);
      pulse(3'h0, 1'b1, 1'b0);
      chk({7'h00, cpu_run}, 8'h00);
      repeat (5) @(posedge clk_i);
      #1 chk({6'h00, mode}, 8'h01);
      pulse(3'h0, 1'b0, 1'b1);
      wait_mode(2'h0, 3);
      rd_reg(`LPW_REG_IRQ_STAT, 8'h01);
      chk({7'h00, irq_out}, 8'h00);
      wr_reg(`LPW_REG_IRQ_MASK, 8'h0f);
      chk({7'h00, irq_out}, 8'h01);
      wr_reg(`LPW_REG_IRQ_STAT, 8'h01);
      chk({7'h00, irq_out}, 8'h00);
      for (int k = 0; k < 3; k++) begin
         wr_reg(`LPW_REG_WAKE_EN, wen(k));
         wr_reg(`LPW_REG_PWR_CTRL, 8'h02);
         pulse(3'h0, 1'b1, 1'b0);
         chk({7'h00, osc_run}, 8'h00);
         pulse(3'h1 << k, 1'b0, 1'b0);
         wait_mode(2'h3, 8);
         wait_mode(2'h0, 260);
         chk({7'h00, irq_out}, 8'h01);
         rd_reg(`LPW_REG_IRQ_STAT, 8'h02 << k);
         wr_reg(`LPW_REG_IRQ_STAT, 8'h0f);
         rd_reg(`LPW_REG_IRQ_STAT, 8'h00);
      end
      wr_reg(`LPW_REG_WAKE_EN, 8'h00);
      wr_reg(`LPW_REG_PORT2, 8'h5a);
      wr_reg(`LPW_REG_PWR_CTRL, 8'h02);
      pulse(3'h0, 1'b1, 1'b0);
      pulse(3'h7, 1'b0, 1'b0);
      repeat (20) @(posedge clk_i);
      #1 chk({6'h00, mode}, 8'h02);
      @(posedge clk_i);
      rst_b_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      rst_b_i <= 1'b1;
      rd_reg(`LPW_REG_PORT2, 8'hff);
      chk({6'h00, mode}, 8'h00);
      finish_test();
   end
endmodule
bind lpw_wake_ctrl lpw_wake_checker i_chk (.clk_i, .rst_b_i, .core_irq_i, .instr_done_i,
   .ext_prog_i, .cpu_ext_cycle_i, .cpu_addr16_i, .cpu_addr_hi_i, .cpu_ad_out_i,
   .core_clk_en_o, .cpu_run_o, .periph_run_o, .osc_run_o, .ext_irq0_int_b_o,
   .ext_irq1_int_b_o, .ale_o, .program_store_strobe_b_o, .port0_o, .port0_oe_o,
   .port_two_latch_o, .mode_o);
`default_nettype wire
